/* hdl/cedt_consts.svh */
// Constants of the CAN error, diagnosis and bit stamp block.
// Assumes an APB slave with byte addresses and 32-bit data words.
`ifndef CEDT_CONSTS_SVH
`define CEDT_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CEDT_OFS_ERR_COUNTS 8'h00
`define CEDT_OFS_DIAG 8'h04
`define CEDT_OFS_STAMP 8'h08
`define CEDT_OFS_CTRL 8'h0C
`define CEDT_OFS_TIMING 8'h10
`define CEDT_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CEDT_EC_REC_LSB 8
`define CEDT_EC_TEC_LSB 0
`define CEDT_DG_CODE_LSB 0
`define CEDT_DG_INDEX_LSB 4
`define CEDT_DG_TX_BIT 10
`define CEDT_DG_STUFF_BIT 11
`define CEDT_DG_CRC_BIT 12
`define CEDT_DG_SAMPLE_BIT 13
`define CEDT_DG_DRIVE_BIT 14
`define CEDT_CT_ENABLE_BIT 0
`define CEDT_CT_STAMP_CLR_BIT 1
`define CEDT_CT_ERR_IE_BIT 2
`define CEDT_TM_PSC_LSB 0
`define CEDT_TM_SEG1_LSB 6
`define CEDT_TM_SEG2_LSB 10
`define CEDT_ST_ERR_PEND_BIT 0
`define CEDT_ST_BUSY_BIT 1
`define CEDT_ST_OVERRUN_BIT 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CEDT_RST_DIAG 16'h0000
`define CEDT_RST_STAMP 16'h0000
`define CEDT_RST_TIMING 13'h0000
`define CEDT_RST_CTRL 3'h0

// ----------------------------------------------------------------
// Field offsets of the bit time encoding and cycle budgets
// ----------------------------------------------------------------
`define CEDT_PSC_ADD 2
`define CEDT_SEG1_ADD 1
`define CEDT_SEG2_ADD 1
`define CEDT_SYNC_TQ 1
`define CEDT_CYC_COPY 17
`define CEDT_CYC_UPDATE 3
`define CEDT_CYC_SCHED 2
`define CEDT_GAP_BITS 4
`define CEDT_TX_ERR_STEP 8
`define CEDT_RX_ERR_STEP 1

`endif

/* hdl/cedt_pkg.sv */
// Types of the CAN error, diagnosis and bit stamp block.
// Constants live in cedt_consts.svh.
package cedt_pkg;

	// Internal task sequencer, Gray coded along idle-copy-update-sched
	typedef enum logic [1:0] {
		CEDT_IDLE = 2'b00,
		CEDT_COPY = 2'b01,
		CEDT_UPDATE = 2'b11,
		CEDT_SCHED = 2'b10
	} cedt_task_t;

	// Frame field codes of the diagnosis record
	typedef enum logic [3:0] {
		CEDT_F_ERROR = 4'h0,
		CEDT_F_ERROR_DEL = 4'h1,
		CEDT_F_ERROR_ECHO = 4'h2,
		CEDT_F_BUS_IDLE = 4'h3,
		CEDT_F_ACK = 4'h4,
		CEDT_F_EOF = 4'h5,
		CEDT_F_INTERMISSION = 4'h6,
		CEDT_F_SUSPEND = 4'h7,
		CEDT_F_SOF = 4'h8,
		CEDT_F_ARBITRATION = 4'h9,
		CEDT_F_IDE = 4'hA,
		CEDT_F_EXT_ARB = 4'hB,
		CEDT_F_RESERVED = 4'hC,
		CEDT_F_DLC = 4'hD,
		CEDT_F_DATA = 4'hE,
		CEDT_F_CRC = 4'hF
	} cedt_field_t;

endpackage

/* hdl/cedt_core.sv */
// Error counters, last error diagnosis, bit stamp counter, bit time
// generation and internal task budget of one CAN controller.
// Assumes an APB master on pclk and a protocol engine that reports
// field starts, errors and frame completions as one-cycle pulses.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cedt_consts.svh"

module cedt_core #(
	parameter int BUF_IDX_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_rx_pin,
	input wire logic bus_tx_pin,
	output logic core_rx,
	output logic bit_tick,
	output logic module_enable,
	input wire logic field_start,
	input wire logic [3:0] field_code,
	input wire logic [6:0] field_len,
	input wire logic err_evt,
	input wire logic err_stuff,
	input wire logic err_crc,
	input wire logic tx_active,
	input wire logic rx_ok,
	input wire logic tx_ok,
	input wire logic xfer_done,
	input wire logic [BUF_IDX_W-1:0] xfer_buf,
	output logic stamp_we,
	output logic [BUF_IDX_W-1:0] stamp_buf,
	output logic [15:0] stamp_data,
	input wire logic task_start,
	input wire logic task_copy,
	input wire logic [3:0] task_updates,
	input wire logic task_sched,
	output logic task_busy,
	output logic error_irq
);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic wr_acc;
	logic mapped;
	logic [31:0] rd_mux;
	logic [2:0] ctrl_q, ctrl_d;
	logic [12:0] timing_q, timing_d;
	logic [31:0] prdata_q, prdata_d;
	logic [7:0] rec_q, rec_d;
	logic [7:0] tec_q, tec_d;
	logic [15:0] diag_q, diag_d;
	logic [15:0] stamp_q, stamp_d;
	logic pend_q, pend_d;
	logic ovr_q, ovr_d;

	assign wr_acc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
		`CEDT_OFS_ERR_COUNTS: begin
			rd_mux[15:0] = {rec_q, tec_q};
		end
		`CEDT_OFS_DIAG: begin
			rd_mux[15:0] = diag_q;
		end
		`CEDT_OFS_STAMP: begin
			rd_mux[15:0] = stamp_q;
		end
		`CEDT_OFS_CTRL: begin
			rd_mux[2:0] = ctrl_q;
		end
		`CEDT_OFS_TIMING: begin
			rd_mux[12:0] = timing_q;
		end
		`CEDT_OFS_STATUS: begin
			rd_mux[`CEDT_ST_ERR_PEND_BIT] = pend_q;
			rd_mux[`CEDT_ST_BUSY_BIT] = task_busy;
			rd_mux[`CEDT_ST_OVERRUN_BIT] = ovr_q;
		end
		default: begin
			mapped = 1'b0;
		end
		endcase
	end

	// Read data latched in setup so it comes from a flop in access
	always_comb begin
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			prdata_d = rd_mux;
		end
		ctrl_d = ctrl_q;
		timing_d = timing_q;
		// Writes to the read-only registers are dropped silently
		if (wr_acc && paddr == `CEDT_OFS_CTRL) begin
			ctrl_d = pwdata[2:0];
		end
		if (wr_acc && paddr == `CEDT_OFS_TIMING) begin
			timing_d = pwdata[12:0];
		end
	end

	// Only presetn clears configuration; disable leaves it intact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			ctrl_q <= `CEDT_RST_CTRL;
			timing_q <= `CEDT_RST_TIMING;
		end else begin
			prdata_q <= prdata_d;
			ctrl_q <= ctrl_d;
			timing_q <= timing_d;
		end
	end

	assign prdata = prdata_q;
	assign module_enable = ctrl_q[`CEDT_CT_ENABLE_BIT];

	// ----------------------------------------------------------------
	// Receive path gate and bit time
	// ----------------------------------------------------------------
	logic rx_q, rx_d;
	logic [6:0] prescaler_ratio;
	logic [4:0] bit_tq;
	logic [6:0] qcnt_q, qcnt_d;
	logic [4:0] tqcnt_q, tqcnt_d;
	logic tick_q, tick_d;

	// Prescaler up to 65, bit up to 25 quanta
	assign prescaler_ratio = 7'(timing_q[5:0]) + 7'(`CEDT_PSC_ADD);
	assign bit_tq = 5'(`CEDT_SYNC_TQ)
		+ (5'(timing_q[9:6]) + 5'(`CEDT_SEG1_ADD))
		+ (5'(timing_q[12:10]) + 5'(`CEDT_SEG2_ADD));

	always_comb begin
		// Recessive seen by the engine while disabled
		rx_d = module_enable ? bus_rx_pin : 1'b1;
		qcnt_d = 7'h00;
		tqcnt_d = 5'h00;
		tick_d = 1'b0;
		if (module_enable) begin
			qcnt_d = qcnt_q + 7'h01;
			tqcnt_d = tqcnt_q;
			if (qcnt_q >= prescaler_ratio - 7'h01) begin
				qcnt_d = 7'h00;
				tqcnt_d = tqcnt_q + 5'h01;
				if (tqcnt_q >= bit_tq - 5'h01) begin
					tqcnt_d = 5'h00;
					tick_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= 1'b1;
			qcnt_q <= 7'h00;
			tqcnt_q <= 5'h00;
			tick_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			qcnt_q <= qcnt_d;
			tqcnt_q <= tqcnt_d;
			tick_q <= tick_d;
		end
	end

	assign core_rx = rx_q;
	assign bit_tick = tick_q;

	// ----------------------------------------------------------------
	// Field tracking, error counters and diagnosis
	// ----------------------------------------------------------------
	logic [3:0] fcode_q, fcode_d;
	logic [5:0] bidx_q, bidx_d;
	logic [8:0] tec_sum;

	assign tec_sum = 9'(tec_q) + 9'(`CEDT_TX_ERR_STEP);

	always_comb begin
		fcode_d = fcode_q;
		bidx_d = bidx_q;
		// A new field wins over a bit tick in the same cycle
		if (field_start) begin
			fcode_d = field_code;
			bidx_d = 6'(field_len - 7'h01);
		end else if (tick_q) begin
			bidx_d = bidx_q - 6'h01;
		end
		rec_d = rec_q;
		tec_d = tec_q;
		diag_d = diag_q;
		if (err_evt) begin
			diag_d = 16'h0000;
			diag_d[3:0] = fcode_q;
			diag_d[9:4] = bidx_q;
			diag_d[`CEDT_DG_TX_BIT] = tx_active;
			diag_d[`CEDT_DG_STUFF_BIT] = err_stuff;
			diag_d[`CEDT_DG_CRC_BIT] = err_crc;
			diag_d[`CEDT_DG_SAMPLE_BIT] = rx_q;
			diag_d[`CEDT_DG_DRIVE_BIT] = bus_tx_pin;
			// Counters saturate; bus-off state is the engine's job
			if (tx_active) begin
				tec_d = tec_sum[8] ? 8'hFF : tec_sum[7:0];
			end else if (rec_q != 8'hFF) begin
				rec_d = rec_q + 8'(`CEDT_RX_ERR_STEP);
			end
		end else begin
			if (rx_ok && rec_q != 8'h00) begin
				rec_d = rec_q - 8'h01;
			end
			if (tx_ok && tec_q != 8'h00) begin
				tec_d = tec_q - 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcode_q <= 4'h0;
			bidx_q <= 6'h00;
			rec_q <= 8'h00;
			tec_q <= 8'h00;
			diag_q <= `CEDT_RST_DIAG;
		end else begin
			fcode_q <= fcode_d;
			bidx_q <= bidx_d;
			rec_q <= rec_d;
			tec_q <= tec_d;
			diag_q <= diag_d;
		end
	end

	// ----------------------------------------------------------------
	// Bit stamp counter and capture
	// ----------------------------------------------------------------
	logic swe_q, swe_d;
	logic [BUF_IDX_W-1:0] sbuf_q, sbuf_d;
	logic [15:0] sdat_q, sdat_d;

	always_comb begin
		stamp_d = stamp_q;
		if (tick_q) begin
			stamp_d = stamp_q + 16'h0001;
		end
		if (xfer_done && xfer_buf == '0
			&& ctrl_q[`CEDT_CT_STAMP_CLR_BIT]) begin
			stamp_d = 16'h0000;
		end
		swe_d = xfer_done;
		sbuf_d = xfer_done ? xfer_buf : sbuf_q;
		sdat_d = xfer_done ? stamp_q : sdat_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_q <= `CEDT_RST_STAMP;
			swe_q <= 1'b0;
			sbuf_q <= '0;
			sdat_q <= 16'h0000;
		end else begin
			stamp_q <= stamp_d;
			swe_q <= swe_d;
			sbuf_q <= sbuf_d;
			sdat_q <= sdat_d;
		end
	end

	assign stamp_we = swe_q;
	assign stamp_buf = sbuf_q;
	assign stamp_data = sdat_q;

	// ----------------------------------------------------------------
	// Internal task budget and inter-frame gap watch
	// ----------------------------------------------------------------
	cedt_pkg::cedt_task_t st_q, st_d;
	logic [4:0] cyc_q, cyc_d;
	logic [3:0] upd_q, upd_d;
	logic sch_q, sch_d;
	logic [2:0] gap_q, gap_d;

	always_comb begin
		st_d = st_q;
		cyc_d = cyc_q;
		upd_d = upd_q;
		sch_d = sch_q;
		case (st_q)
		cedt_pkg::CEDT_IDLE: begin
			if (task_start) begin
				upd_d = task_updates;
				sch_d = task_sched;
				if (task_copy) begin
					st_d = cedt_pkg::CEDT_COPY;
					cyc_d = 5'(`CEDT_CYC_COPY - 1);
				end else if (task_updates != 4'h0) begin
					st_d = cedt_pkg::CEDT_UPDATE;
					cyc_d = 5'(`CEDT_CYC_UPDATE - 1);
				end else if (task_sched) begin
					st_d = cedt_pkg::CEDT_SCHED;
					cyc_d = 5'(`CEDT_CYC_SCHED - 1);
				end
			end
		end
		cedt_pkg::CEDT_COPY: begin
			cyc_d = cyc_q - 5'h01;
			if (cyc_q == 5'h00) begin
				if (upd_q != 4'h0) begin
					st_d = cedt_pkg::CEDT_UPDATE;
					cyc_d = 5'(`CEDT_CYC_UPDATE - 1);
				end else if (sch_q) begin
					st_d = cedt_pkg::CEDT_SCHED;
					cyc_d = 5'(`CEDT_CYC_SCHED - 1);
				end else begin
					st_d = cedt_pkg::CEDT_IDLE;
				end
			end
		end
		cedt_pkg::CEDT_UPDATE: begin
			cyc_d = cyc_q - 5'h01;
			if (cyc_q == 5'h00) begin
				upd_d = upd_q - 4'h1;
				cyc_d = 5'(`CEDT_CYC_UPDATE - 1);
				if (upd_q == 4'h1) begin
					if (sch_q) begin
						st_d = cedt_pkg::CEDT_SCHED;
						cyc_d = 5'(`CEDT_CYC_SCHED - 1);
					end else begin
						st_d = cedt_pkg::CEDT_IDLE;
					end
				end
			end
		end
		cedt_pkg::CEDT_SCHED: begin
			cyc_d = cyc_q - 5'h01;
			if (cyc_q == 5'h00) begin
				st_d = cedt_pkg::CEDT_IDLE;
				sch_d = 1'b0;
			end
		end
		default: begin
			st_d = cedt_pkg::CEDT_IDLE;
		end
		endcase
	end

	// Gap of four bits from the validation point; busy past it overruns
	always_comb begin
		gap_d = gap_q;
		if (task_start) begin
			gap_d = 3'(`CEDT_GAP_BITS);
		end else if (tick_q && gap_q != 3'h0) begin
			gap_d = gap_q - 3'h1;
		end
		// Hardware set wins over software clear (write 1 to clear)
		ovr_d = ovr_q;
		if (wr_acc && paddr == `CEDT_OFS_STATUS
			&& pwdata[`CEDT_ST_OVERRUN_BIT]) begin
			ovr_d = 1'b0;
		end
		if (tick_q && gap_q == 3'h1 && st_q != cedt_pkg::CEDT_IDLE) begin
			ovr_d = 1'b1;
		end
		pend_d = pend_q;
		if (wr_acc && paddr == `CEDT_OFS_STATUS
			&& pwdata[`CEDT_ST_ERR_PEND_BIT]) begin
			pend_d = 1'b0;
		end
		if (rec_d != rec_q || tec_d != tec_q) begin
			pend_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= cedt_pkg::CEDT_IDLE;
			cyc_q <= 5'h00;
			upd_q <= 4'h0;
			sch_q <= 1'b0;
			gap_q <= 3'h0;
			ovr_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cyc_q <= cyc_d;
			upd_q <= upd_d;
			sch_q <= sch_d;
			gap_q <= gap_d;
			ovr_q <= ovr_d;
			pend_q <= pend_d;
		end
	end

	assign task_busy = st_q != cedt_pkg::CEDT_IDLE;
	assign error_irq = pend_q && ctrl_q[`CEDT_CT_ERR_IE_BIT];

endmodule

/* tb/cedt_core_asserts.sv */
// Checker for cedt_core, bound to its ports.
// Assumes one pclk domain and the active-low presetn.
`timescale 1ns/1ps
module cedt_core_asserts #(
	parameter int BUF_IDX_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic bus_rx_pin,
	input wire logic core_rx,
	input wire logic bit_tick,
	input wire logic module_enable,
	input wire logic xfer_done,
	input wire logic [BUF_IDX_W-1:0] xfer_buf,
	input wire logic stamp_we,
	input wire logic [BUF_IDX_W-1:0] stamp_buf,
	input wire logic task_start,
	input wire logic task_copy,
	input wire logic [3:0] task_updates,
	input wire logic task_sched,
	input wire logic task_busy,
	input wire logic error_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Busy length tracker
	// ----------------------------------------
	logic [7:0] cnt_q, cnt_d, exp_q, exp_d;
	always_comb begin
		cnt_d = task_busy ? cnt_q + 8'h01 : cnt_q;
		exp_d = exp_q;
		if (task_start && !task_busy) begin
			cnt_d = 8'h00;
			exp_d = 8'(17 * task_copy + 3 * task_updates + 2 * task_sched);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			exp_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end
	property p_rx_off;
		!module_enable && !$past(module_enable) |-> core_rx;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("core_rx not idle while disabled");
	property p_rx_pass;
		module_enable && $past(module_enable) |-> core_rx == $past(bus_rx_pin);
	endproperty
	a_rx_pass: assert property (p_rx_pass)
		else $error("core_rx does not follow the pin");
	property p_tick_off;
		!module_enable && !$past(module_enable) |-> !bit_tick;
	endproperty
	a_tick_off: assert property (p_tick_off)
		else $error("bit tick while disabled");
	property p_bit_min;
		bit_tick |=> !bit_tick [*7];
	endproperty
	a_bit_min: assert property (p_bit_min)
		else $error("bit shorter than eight clocks");
	property p_stamp_pulse;
		1'h1 |-> stamp_we == $past(xfer_done);
	endproperty
	a_stamp_pulse: assert property (p_stamp_pulse)
		else $error("stamp write not one cycle after transfer");
	property p_stamp_buf;
		stamp_we |-> stamp_buf == $past(xfer_buf);
	endproperty
	a_stamp_buf: assert property (p_stamp_buf)
		else $error("stamp written to wrong buffer");
	property p_task_len;
		$fell(task_busy) |-> cnt_q == exp_q;
	endproperty
	a_task_len: assert property (p_task_len)
		else $error("task budget length wrong");
	property p_irq_hold;
		error_irq && !(psel && penable && pwrite) |=> error_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("error request dropped without a write");
	c_stamp: cover property (stamp_we);
	c_task: cover property ($fell(task_busy));
	c_irq: cover property ($rose(error_irq));
endmodule

bind cedt_core cedt_core_asserts #(.BUF_IDX_W(BUF_IDX_W))
	cedt_core_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.bus_rx_pin, .core_rx, .bit_tick, .module_enable, .xfer_done,
	.xfer_buf, .stamp_we, .stamp_buf, .task_start, .task_copy,
	.task_updates, .task_sched, .task_busy, .error_irq);

/* tb/cedt_xcvr_model.sv */
// Transceiver model: the wired bus level seen on the receive pin.
// Assumes dominant is low and a peer node may pull dominant.
`timescale 1ns/1ps
module cedt_xcvr_model (
	input wire logic tx_level,
	input wire logic peer_dominant,
	output logic bus_level
);
	// Dominant wins; recessive only when nobody pulls low
	assign bus_level = tx_level & ~peer_dominant;
endmodule

/* tb/test_cedt_core.sv */
// Self-checking bench for cedt_core with a transceiver model.
// Assumes a zero-wait APB slave and one 125 MHz clock.
`timescale 1ns/1ps
`include "cedt_consts.svh"
module test_cedt_core;
	logic pclk = 1'h0, presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, tm;
	logic pready, pslverr, bus_rx_pin, core_rx, bit_tick, module_enable;
	logic bus_tx_pin = 1'h1, peer_dom = 1'h0, field_start = 1'h0;
	logic err_evt = 1'h0, err_stuff = 1'h0, err_crc = 1'h0;
	logic tx_active = 1'h0, rx_ok = 1'h0, tx_ok = 1'h0, xfer_done = 1'h0;
	logic task_start = 1'h0, task_copy = 1'h0, task_sched = 1'h0;
	logic [3:0] field_code = 4'h0, task_updates = 4'h0, xfer_buf = 4'h0;
	logic [6:0] field_len = 7'h00;
	logic stamp_we, task_busy, error_irq, txa, st, cr;
	logic [3:0] stamp_buf;
	logic [15:0] stamp_data, shadow = 16'h0000;
	logic clr_en = 1'h0, gap_chk = 1'h0, seen = 1'h0;
	logic [31:0] rq[$];
	logic [19:0] sq[$];
	int miscompares = 0, tests_run = 0, gap = 0, bit_len, receive_error_count, transmit_error_count, n;
	int ul[3] = '{0, 1, 14};

	always #4 pclk = ~pclk;

	cedt_core #(.BUF_IDX_W(4)) cedt_core_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.bus_rx_pin, .bus_tx_pin, .core_rx, .bit_tick, .module_enable,
		.field_start, .field_code, .field_len, .err_evt, .err_stuff,
		.err_crc, .tx_active, .rx_ok, .tx_ok, .xfer_done, .xfer_buf,
		.stamp_we, .stamp_buf, .stamp_data, .task_start, .task_copy,
		.task_updates, .task_sched, .task_busy, .error_irq);
	cedt_xcvr_model cedt_xcvr_model_inst (.tx_level(bus_tx_pin),
		.peer_dominant(peer_dom), .bus_level(bus_rx_pin));

	// ----------------------------------------
	// Checking and ending
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			$display("[ERR] wait exp done got timeout");
			miscompares++;
			close_out();
		end
	endtask
	// Read results and stamp writes come off the queues here
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready)
			chk("prdata", rq.pop_front(), prdata);
		if (psel && penable && pready)
			chk("pslverr", {31'h0, paddr > 8'h14}, {31'h0, pslverr});
		if (stamp_we === 1'h1)
			chk("stamp", {12'h000, sq.pop_front()}, {12'h000, stamp_buf, stamp_data});
		if (xfer_done === 1'h1)
			sq.push_back({xfer_buf, shadow});
		if (xfer_done && xfer_buf == 4'h0 && clr_en)
			shadow <= 16'h0000;
		else if (bit_tick === 1'h1)
			shadow <= shadow + 16'h0001;
		if (bit_tick === 1'h1) begin
			if (gap_chk && seen)
				chk("bit gap", bit_len, gap);
			seen <= gap_chk;
			gap <= 1;
		end else
			gap <= gap + 1;
	end

	// ----------------------------------------
	// Bus and event drivers
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk);
		while (pready !== 1'h1 && ++k < 50);
		bound(k, 50);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'h0, a, 32'h0000_0000);
	endtask
	task automatic wtick();
		int k;
		k = 0;
		do @(posedge pclk);
		while (bit_tick !== 1'h1 && ++k < 3000);
		bound(k, 3000);
	endtask
	task automatic xfer(input logic [3:0] b);
		@(posedge pclk);
		xfer_done <= 1'h1;
		xfer_buf <= b;
		@(posedge pclk);
		xfer_done <= 1'h0;
	endtask

	initial begin
		int ln, k;
		void'($urandom(74466));
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		for (int a = 0; a < 6; a++)
			rd(8'(a * 4), 32'h0000_0000);
		for (int a = 0; a < 3; a++)
			apb(1'h1, 8'(a * 4), 32'hFFFF_FFFF);
		for (int a = 0; a < 3; a++)
			rd(8'(a * 4), 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		tm = {19'h0_0000, 3'($urandom_range(7, 0)),
			4'($urandom_range(15, 1)), 6'($urandom_range(3, 2))};
		// Sixteen clocks a bit or more leave the worst task budget room
		bit_len = (tm[9:6] + tm[12:10] + 3) * (tm[5:0] + 2);
		apb(1'h1, `CEDT_OFS_TIMING, tm);
		apb(1'h1, `CEDT_OFS_CTRL, 32'h0000_0007);
		clr_en <= 1'h1;
		gap_chk <= 1'h1;
		receive_error_count = 0;
		transmit_error_count = 0;
		for (int c = 0; c < 16; c++) begin
			ln = $urandom_range(64, 4);
			k = $urandom_range(2, 1);
			{txa, st, cr} = 3'($urandom());
			wtick();
			field_start <= 1'h1;
			field_code <= 4'(c);
			field_len <= 7'(ln);
			bus_tx_pin <= 1'($urandom());
			peer_dom <= 1'($urandom());
			@(posedge pclk);
			field_start <= 1'h0;
			repeat (k) wtick();
			err_evt <= 1'h1;
			tx_active <= txa;
			err_stuff <= st;
			err_crc <= cr;
			@(posedge pclk);
			err_evt <= 1'h0;
			// Sixteen errors cannot reach saturation
			if (txa)
				transmit_error_count = transmit_error_count + 8;
			else
				receive_error_count = receive_error_count + 1;
			rd(`CEDT_OFS_DIAG, {17'h0_0000, bus_tx_pin, bus_rx_pin, cr, st,
				txa, 6'(ln - 1 - k), 4'(c)});
		end
		rd(`CEDT_OFS_ERR_COUNTS, {16'h0000, 8'(receive_error_count), 8'(transmit_error_count)});
		rd(`CEDT_OFS_STATUS, 32'h0000_0001);
		chk("error_irq", 32'h0000_0001, {31'h0, error_irq});
		apb(1'h1, `CEDT_OFS_STATUS, 32'h0000_0001);
		rd(`CEDT_OFS_STATUS, 32'h0000_0000);
		@(posedge pclk);
		rx_ok <= 1'h1;
		tx_ok <= 1'h1;
		@(posedge pclk);
		rx_ok <= 1'h0;
		tx_ok <= 1'h0;
		rd(`CEDT_OFS_ERR_COUNTS, {16'h0000, 8'(receive_error_count > 0 ? receive_error_count - 1 : 0),
			8'(transmit_error_count > 0 ? transmit_error_count - 1 : 0)});
		xfer(4'h3);
		xfer(4'h0);
		for (int i = 0; i < 3; i++) begin
			// Gap window opens on a bit boundary, as after validation
			wtick();
			@(posedge pclk);
			task_start <= 1'h1;
			task_copy <= 1'h1;
			task_sched <= 1'h1;
			task_updates <= 4'(ul[i]);
			@(posedge pclk);
			task_start <= 1'h0;
			n = 0;
			do @(posedge pclk);
			while (task_busy === 1'h1 && ++n < 300);
			chk("busy cycles", 19 + 3 * ul[i], n);
		end
		rd(`CEDT_OFS_STATUS, 32'h0000_0001);
		gap_chk <= 1'h0;
		apb(1'h1, `CEDT_OFS_CTRL, 32'h0000_0006);
		peer_dom <= 1'h1;
		repeat (3) @(posedge pclk);
		chk("core_rx", 32'h0000_0001, {31'h0, core_rx});
		chk("module_enable", 32'h0000_0000, {31'h0, module_enable});
		rd(`CEDT_OFS_CTRL, 32'h0000_0006);
		rd(`CEDT_OFS_TIMING, tm);
		rd(`CEDT_OFS_STAMP, {16'h0000, shadow});
		@(posedge pclk);
		close_out();
	end
endmodule
